// File: acr_regs.svh
// Register offsets, reset values and field positions of the amplifier
// control bank. Assumes byte-wide registers on an 8-bit register address.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_ADDR_IDENT 8'h00
`define ACR_ADDR_POWER 8'h01
`define ACR_ADDR_DIGCTL 8'h02
`define ACR_ADDR_VOLCFG 8'h03
`define ACR_ADDR_VOL_L 8'h04
`define ACR_ADDR_VOL_R 8'h05
`define ACR_ADDR_ANALOG 8'h06
`define ACR_ADDR_RSVD7 8'h07
`define ACR_ADDR_FAULT 8'h08
`define ACR_ADDR_CLIP_MID 8'h10
`define ACR_ADDR_CLIP_LOW 8'h11

`define ACR_RST_POWER 8'hfd
`define ACR_RST_DIGCTL 8'h14
`define ACR_RST_VOLCFG 8'h80
`define ACR_RST_VOL 8'hcf
`define ACR_RST_ANALOG 8'h51
`define ACR_RST_FAULT 8'h00
`define ACR_RST_FLAGS 4'h0
`define ACR_RST_CLIP_MID 8'hff
`define ACR_RST_CLIP_LOW 8'hfc

// Writable bit masks; reserved bits keep their reset value
`define ACR_WMASK_DIGCTL 8'hbf
`define ACR_WMASK_VOLCFG 8'h83
`define ACR_WMASK_ANALOG 8'hfe
`define ACR_WMASK_FAULT 8'h30

`define ACR_BIT_SLEEP 1
`define ACR_BIT_PDN 0
`define ACR_NUM_FAULTS 4

`endif

// File: acr_pkg.sv
// Types shared by the amplifier control bank modules.
// Assumes the offsets and reset values come from acr_regs.svh.
package acr_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acr_req_t;

    typedef struct packed {
        logic highpass_skip;
        logic [1:0] digital_boost;
        logic rate_speed_select;
        logic [2:0] input_format;
        logic fade_enable;
        logic mute_right;
        logic mute_left;
        logic [7:0] left_volume;
        logic [7:0] right_volume;
        logic parallel_bridge_mode;
        logic [2:0] pwm_rate_sel;
        logic [1:0] analog_gain;
        logic bridge_channel_sel;
        logic [1:0] overcurrent_limit_sel;
    } acr_ctrl_t;

    typedef struct packed {
        logic clock_fault_flag;
        logic overcurrent_flag;
        logic dc_offset_fault_flag;
        logic overtemp_flag;
    } acr_fault_t;

    typedef enum logic [2:0] {
        ACR_PWR_OFF = 3'b001,
        ACR_PWR_SLEEP = 3'b010,
        ACR_PWR_PLAY = 3'b100
    } acr_pwr_t;
endpackage

// File: acr_fault_status.sv
// Fault status flags of the amplifier control bank.
// Assumes fault events are synchronous single-cycle or level inputs.
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"
module acr_fault_status (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events and clear
    input wire acr_pkg::acr_fault_t fault_evt,
    input wire logic clear,
    // Status
    output acr_pkg::acr_fault_t flags
);
    import acr_pkg::*;

    logic [`ACR_NUM_FAULTS-1:0] flag_q;
    logic [`ACR_NUM_FAULTS-1:0] flag_d;
    logic [`ACR_NUM_FAULTS-1:0] evt_w;

    assign evt_w = fault_evt;

    // Sticky flags
    // A new event wins over a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < `ACR_NUM_FAULTS; g++) begin : g_flag
            assign flag_d[g] = evt_w[g] | (flag_q[g] & ~clear);
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_q <= `ACR_RST_FLAGS;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flags = flag_q;

    property p_fault_set;
        @(posedge clk) disable iff (!rst_n)
        (|evt_w) |=> ((flag_q & $past(evt_w)) == $past(evt_w));
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault event did not set its flag");
endmodule
`default_nettype wire

// File: amp_control_register_bank.sv
// Control register bank of the amplifier, reached as byte registers.
// Assumes the serial control engine hands over one-cycle write and read
// strobes with a register address, and takes read data the next cycle.
//
// Overview of operation
// - Clip threshold bits 19:14 live in power control bits 7:2.
// - Threshold middle bits from 0x10, low six from 0x11 upper bits.
// - Sleep bit set with shutdown bit at 1 disables power stage, low-voltage blocks on standby.
// - Sleep bit resets to 0; writing 0 with shutdown bit at 1 resumes playback.
// - Shutdown bit at 0 powers down logic and power-stage domains.
// - Shutdown bit resets to 1, amplifier running after reset.
// - Digital control resets to 0x14 with its documented fields.
`timescale 1ns/1ns
`default_nettype none
`include "acr_regs.svh"
module amp_control_register_bank #(
    parameter logic [7:0] IDENT_VALUE = 8'h3c // Arbitrary identity value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register access from the serial engine
    input wire acr_pkg::acr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Fault inputs
    input wire acr_pkg::acr_fault_t fault_evt,
    // Controls to the datapath and power stage
    output acr_pkg::acr_ctrl_t ctrl,
    output logic [19:0] clip_threshold_level,
    output logic amp_sleep_ctl,
    output logic amp_power_down_n,
    output logic stage_enable,
    output logic lv_standby,
    output logic domains_off
);
    import acr_pkg::*;

    logic [7:0] power_q, digctl_q, volcfg_q, voll_q, volr_q;
    logic [7:0] analog_q, faultcfg_q, clipm_q, clipl_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    acr_pwr_t pwr_d;
    logic stage_q, standby_q, off_q;
    acr_fault_t flags_w;
    logic fault_clr_w;

    function automatic logic hit(input acr_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    logic wr_pow, wr_dig, wr_vcf, wr_vl, wr_vr, wr_ana, wr_flt;
    logic wr_cm, wr_cl;
    assign wr_pow = hit(req, `ACR_ADDR_POWER);
    assign wr_dig = hit(req, `ACR_ADDR_DIGCTL);
    assign wr_vcf = hit(req, `ACR_ADDR_VOLCFG);
    assign wr_vl = hit(req, `ACR_ADDR_VOL_L);
    assign wr_vr = hit(req, `ACR_ADDR_VOL_R);
    assign wr_ana = hit(req, `ACR_ADDR_ANALOG);
    assign wr_flt = hit(req, `ACR_ADDR_FAULT);
    assign wr_cm = hit(req, `ACR_ADDR_CLIP_MID);
    assign wr_cl = hit(req, `ACR_ADDR_CLIP_LOW);

    // Reading the fault register clears the error flags it reported
    assign fault_clr_w = req.rd && (req.addr == `ACR_ADDR_FAULT);

    acr_fault_status u_fault (
        .clk(clk),
        .rst_n(rst_n),
        .fault_evt(fault_evt),
        .clear(fault_clr_w),
        .flags(flags_w)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_q <= `ACR_RST_POWER;
            digctl_q <= `ACR_RST_DIGCTL;
            volcfg_q <= `ACR_RST_VOLCFG;
            voll_q <= `ACR_RST_VOL;
            volr_q <= `ACR_RST_VOL;
            analog_q <= `ACR_RST_ANALOG;
            faultcfg_q <= `ACR_RST_FAULT;
            clipm_q <= `ACR_RST_CLIP_MID;
            clipl_q <= `ACR_RST_CLIP_LOW;
        end else begin
            if (wr_pow) power_q <= req.wdata;
            if (wr_dig) digctl_q <= merge(digctl_q, req.wdata,
                                          `ACR_WMASK_DIGCTL);
            if (wr_vcf) volcfg_q <= merge(volcfg_q, req.wdata,
                                          `ACR_WMASK_VOLCFG);
            if (wr_vl) voll_q <= req.wdata;
            if (wr_vr) volr_q <= req.wdata;
            if (wr_ana) analog_q <= merge(analog_q, req.wdata,
                                          `ACR_WMASK_ANALOG);
            if (wr_flt) faultcfg_q <= merge(faultcfg_q, req.wdata,
                                            `ACR_WMASK_FAULT);
            if (wr_cm) clipm_q <= req.wdata;
            if (wr_cl) clipl_q <= req.wdata;
        end
    end

    // Read mux; unmapped offsets read as zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            `ACR_ADDR_IDENT: rd_mux = IDENT_VALUE;
            `ACR_ADDR_POWER: rd_mux = power_q;
            `ACR_ADDR_DIGCTL: rd_mux = digctl_q;
            `ACR_ADDR_VOLCFG: rd_mux = volcfg_q;
            `ACR_ADDR_VOL_L: rd_mux = voll_q;
            `ACR_ADDR_VOL_R: rd_mux = volr_q;
            `ACR_ADDR_ANALOG: rd_mux = analog_q;
            `ACR_ADDR_FAULT: rd_mux = faultcfg_q | {4'h0, flags_w};
            `ACR_ADDR_CLIP_MID: rd_mux = clipm_q;
            `ACR_ADDR_CLIP_LOW: rd_mux = clipl_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd) rdata_q <= rd_mux;
        end
    end

    always_comb begin
        if (!power_q[`ACR_BIT_PDN]) begin
            pwr_d = ACR_PWR_OFF;
        end else if (power_q[`ACR_BIT_SLEEP]) begin
            pwr_d = ACR_PWR_SLEEP;
        end else begin
            pwr_d = ACR_PWR_PLAY;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage_q <= 1'b1;
            standby_q <= 1'b0;
            off_q <= 1'b0;
        end else begin
            stage_q <= (pwr_d == ACR_PWR_PLAY);
            standby_q <= (pwr_d == ACR_PWR_SLEEP);
            off_q <= (pwr_d == ACR_PWR_OFF);
        end
    end

    assign clip_threshold_level = {power_q[7:2], clipm_q, clipl_q[7:2]};
    assign amp_sleep_ctl = power_q[`ACR_BIT_SLEEP];
    assign amp_power_down_n = power_q[`ACR_BIT_PDN];
    assign stage_enable = stage_q;
    assign lv_standby = standby_q;
    assign domains_off = off_q;
    assign rdata = rdata_q;
    assign rvalid = rvalid_q;

    assign ctrl.highpass_skip = digctl_q[7];
    assign ctrl.digital_boost = digctl_q[5:4];
    assign ctrl.rate_speed_select = digctl_q[3];
    assign ctrl.input_format = digctl_q[2:0];
    assign ctrl.fade_enable = volcfg_q[7];
    assign ctrl.mute_right = volcfg_q[1];
    assign ctrl.mute_left = volcfg_q[0];
    assign ctrl.left_volume = voll_q;
    assign ctrl.right_volume = volr_q;
    assign ctrl.parallel_bridge_mode = analog_q[7];
    assign ctrl.pwm_rate_sel = analog_q[6:4];
    assign ctrl.analog_gain = analog_q[3:2];
    assign ctrl.bridge_channel_sel = analog_q[1];
    assign ctrl.overcurrent_limit_sel = faultcfg_q[5:4];

    property p_threshold_top;
        @(posedge clk) disable iff (!rst_n)
        wr_pow |=> clip_threshold_level[19:14] == $past(req.wdata[7:2]);
    endproperty
    a_threshold_top: assert property (p_threshold_top)
        else $error("threshold top bits not from power control");

    property p_threshold_low;
        @(posedge clk) disable iff (!rst_n)
        (wr_cm || wr_cl) |=> clip_threshold_level[13:0] == ($past(wr_cm)
            ? {$past(req.wdata), $past(clipl_q[7:2])}
            : {$past(clipm_q), $past(req.wdata[7:2])});
    endproperty
    a_threshold_low: assert property (p_threshold_low)
        else $error("threshold low bits wrong");

    property p_sleep;
        @(posedge clk) disable iff (!rst_n)
        (wr_pow && req.wdata[1] && req.wdata[0])
            |=> ##1 (lv_standby && !stage_enable && !domains_off);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep did not stop power stage");

    property p_wake;
        @(posedge clk) disable iff (!rst_n)
        (wr_pow && req.wdata[1:0] == 2'b01) |=> ##1 stage_enable;
    endproperty
    a_wake: assert property (p_wake)
        else $error("clearing sleep did not resume");

    property p_shutdown;
        @(posedge clk) disable iff (!rst_n)
        (wr_pow && !req.wdata[0]) |=> ##1 (domains_off && !stage_enable);
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown did not power down");

    property p_reset_power;
        @(posedge clk)
        !rst_n |=> (amp_power_down_n && !amp_sleep_ctl);
    endproperty
    a_reset_power: assert property (p_reset_power)
        else $error("power control reset value wrong");

    property p_digctl_reset;
        @(posedge clk)
        !rst_n |=> (ctrl.digital_boost == 2'b01 && ctrl.input_format == 3'h4
            && !ctrl.highpass_skip && !ctrl.rate_speed_select);
    endproperty
    a_digctl_reset: assert property (p_digctl_reset)
        else $error("digital control reset value wrong");

    property p_fault_read;
        @(posedge clk) disable iff (!rst_n)
        (fault_clr_w && |fault_evt) |=> rvalid &&
            ((flags_w & $past(fault_evt)) == $past(fault_evt));
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("fault read lost a flag");
endmodule
`default_nettype wire

// File: acr_host_model.sv
// Host side model: issues single register writes and reads to the bank.
// Assumes the bank takes strobes at a rising edge and answers next cycle.
`timescale 1ns/1ns
`default_nettype none
module acr_host_model (
    // Clock
    input wire logic clk,
    // Request and answer
    output var acr_pkg::acr_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import acr_pkg::*;
    initial req = '0;
    // Released lines flip, so a stale address is never trusted
    task automatic idle();
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
    endtask
    // Write: register byte then data byte
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                          input int gap);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        idle();
    endtask
    // Read: register byte, one byte back
    task automatic rd_reg(input logic [7:0] a, input int gap,
                          output logic [7:0] d, output logic v);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
        @(negedge clk);
        d = rdata;
        v = rvalid;
        idle();
    endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the amplifier control register bank.
// Assumes acr_host_model drives the request port on falling edges.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import acr_pkg::*;
    localparam logic [7:0] IDENT = 8'h5a; // Arbitrary identity value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    acr_req_t req;
    acr_fault_t fault_evt = '0;
    acr_ctrl_t ctrl;
    logic [7:0] rdata, got, a8;
    logic [19:0] clip;
    logic rvalid, sleep, pdn, stage, lvs, off, v;
    logic [7:0] mdl [0:255];
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    amp_control_register_bank #(.IDENT_VALUE(IDENT)) i_dut (
        .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rvalid(rvalid), .fault_evt(fault_evt), .ctrl(ctrl),
        .clip_threshold_level(clip), .amp_sleep_ctl(sleep),
        .amp_power_down_n(pdn), .stage_enable(stage),
        .lv_standby(lvs), .domains_off(off));
    acr_host_model i_host (.clk(clk), .req(req), .rdata(rdata),
        .rvalid(rvalid));
    // Upper byte: writable bits, lower byte: reset value
    function automatic logic [15:0] reg_info(input int a);
        case (a)
            0: return {8'h00, IDENT};
            1: return 16'hfffd;
            2: return 16'hbf14;
            3: return 16'h8380;
            4, 5: return 16'hffcf;
            6: return 16'hfe51;
            8: return 16'h3000;
            16: return 16'hffff;
            17: return 16'hfffc;
            default: return 16'h0000;
        endcase
    endfunction
    function automatic acr_ctrl_t exp_ctrl();
        return {mdl[2][7], mdl[2][5:4], mdl[2][3], mdl[2][2:0], mdl[3][7],
            mdl[3][1], mdl[3][0], mdl[4], mdl[5], mdl[6][7], mdl[6][6:4],
            mdl[6][3:2], mdl[6][1], mdl[8][5:4]};
    endfunction
    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_out(input string n, input logic [39:0] e,
                           input logic [39:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("Counts: %0d mismatches, %0d comparisons", num_errors,
            comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic do_reset();
        logic [15:0] t;
        rst_n <= 1'b0;
        repeat (5) @(negedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            t = reg_info(i);
            mdl[i] = t[7:0];
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input int gap);
        i_host.rd_reg(a, gap, got, v);
        chk_out("rvalid", 40'd1, {39'd0, v});
        chk_byte("read data", mdl[a], got);
        // Reading the fault register clears its flags
        if (a == 8'h08) mdl[8][3:0] = 4'h0;
    endtask
    task automatic wr_upd(input logic [7:0] a, input logic [7:0] d,
                          input int gap);
        logic [15:0] t;
        t = reg_info(a);
        i_host.wr_reg(a, d, gap);
        mdl[a] = (mdl[a] & ~t[15:8]) | (d & t[15:8]);
    endtask
    // Sleep and shutdown outputs lag a write by one cycle, stage, standby and off by two
    task automatic chk_all();
        logic s, p;
        repeat (2) @(negedge clk);
        s = mdl[1][1];
        p = mdl[1][0];
        chk_out("ctrl", 40'(exp_ctrl()), 40'(ctrl));
        chk_out("clip", 40'({mdl[1][7:2], mdl[16], mdl[17][7:2]}),
            40'(clip));
        chk_out("power", {35'd0, s, p, p & ~s, p & s, ~p},
            {35'd0, sleep, pdn, stage, lvs, off});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        void'($urandom(32));
        do_reset();
        // Reset values, unmapped offsets read as zero
        for (int a = 0; a < 20; a++) rd_chk(8'(a), 0);
        rd_chk(8'hff, 0);
        chk_all();
        // All ones at offsets 0 to 19, zeros at 0xff; read-only and reserved bits must hold
        for (int a = 0; a < 20; a++) wr_upd(8'(a), 8'hff, 0);
        wr_upd(8'hff, 8'h00, 0);
        for (int a = 0; a < 20; a++) rd_chk(8'(a), 0);
        chk_all();
        // Every power state, shutdown outranking sleep
        for (int p = 0; p < 4; p++) begin
            wr_upd(8'h01, {6'h2a, 2'(p)}, 0);
            chk_all();
        end
        // Each fault flag latched, reported, then cleared by the read
        for (int f = 0; f < 4; f++) begin
            @(negedge clk);
            fault_evt <= acr_fault_t'(4'h1 << f);
            @(negedge clk);
            fault_evt <= '0;
            mdl[8][f] = 1'b1;
            rd_chk(8'h08, 1);
            rd_chk(8'h08, 0);
            // Event in the cycle of the clearing read keeps its flag
            fault_evt <= acr_fault_t'(4'h1 << f);
            mdl[8][f] = 1'b1;
            rd_chk(8'h08, 0);
            fault_evt <= '0;
            mdl[8][f] = 1'b1;
            rd_chk(8'h08, 0);
            rd_chk(8'h08, 0);
        end
        // Random traffic with random spacing
        repeat (300) begin
            a8 = 8'($urandom_range(19, 0));
            if ($urandom_range(1, 0) == 1)
                wr_upd(a8, 8'($urandom), $urandom_range(2, 0));
            else
                rd_chk(a8, $urandom_range(2, 0));
            chk_all();
        end
        // Reset in mid-run restores every register
        do_reset();
        for (int a = 0; a < 20; a++) rd_chk(8'(a), 0);
        chk_all();
        end_sim();
    end
endmodule
`default_nettype wire
